// *** fdcrs_pkg.sv ***
// fdcrs_pkg: constants, types and bit layout of the result status flag block
// assumes a single 100 MHz controller clock (mclk) shared by every user
package fdcrs_pkg;

	// bit layout of the command outcome status byte
	localparam int COS_UNIT_LO_BIT   = 0;
	localparam int COS_UNIT_HI_BIT   = 1;
	localparam int COS_HEAD_BIT      = 2;
	localparam int COS_NOT_AVAIL_BIT = 3;
	localparam int COS_EQ_FAULT_BIT  = 4;
	localparam int COS_POS_DONE_BIT  = 5;
	localparam int COS_TERM_LO_BIT   = 6;
	localparam int COS_TERM_HI_BIT   = 7;

	// bit layout of the transfer fault status byte
	localparam int TFS_ID_SYNC_BIT   = 0;
	localparam int TFS_PROTECT_BIT   = 1;
	localparam int TFS_MISSING_BIT   = 2;
	localparam int TFS_UNUSED3_BIT   = 3;
	localparam int TFS_LATE_BIT      = 4;
	localparam int TFS_CRC_BIT       = 5;
	localparam int TFS_UNUSED6_BIT   = 6;
	localparam int TFS_CYL_END_BIT   = 7;

	// reset values
	localparam logic [7:0] COS_RESET = 8'h00;
	localparam logic [7:0] TFS_RESET = 8'h00;

	// counts
	localparam logic [6:0] RECAL_STEP_LIMIT = 7'h4D;
	localparam logic [1:0] INDEX_LIMIT      = 2'h2;
	localparam int         SYNC_WIDTH       = 6;

	// command classes issued by the sequencer
	typedef enum logic [3:0] {
		FDCRS_CMD_SEEK       = 4'h0,
		FDCRS_CMD_RECAL      = 4'h1,
		FDCRS_CMD_READ       = 4'h2,
		FDCRS_CMD_READ_DEL   = 4'h3,
		FDCRS_CMD_WRITE      = 4'h4,
		FDCRS_CMD_WRITE_DEL  = 4'h5,
		FDCRS_CMD_FORMAT     = 4'h6,
		FDCRS_CMD_READ_ID    = 4'h7,
		FDCRS_CMD_READ_TRACK = 4'h8,
		FDCRS_CMD_SCAN       = 4'h9,
		FDCRS_CMD_OTHER      = 4'hF
	} fdcrs_cmd_t;

	typedef enum logic [1:0] {
		FDCRS_ST_IDLE = 2'b01,
		FDCRS_ST_EXEC = 2'b10
	} fdcrs_state_t;

	// raw drive pins, asynchronous to mclk
	typedef struct packed {
		logic fault;
		logic ready;
		logic two_side;
		logic track_zero;
		logic write_protect;
		logic index;
	} fdcrs_drive_t;

	// one-cycle events from the command sequencer, same clock
	typedef struct packed {
		logic id_crc_err;
		logic data_crc_err;
		logic host_late;
		logic sector_not_found;
		logic id_read_fail;
		logic start_sector_lost;
		logic beyond_last_sector;
		logic id_mark_seen;
		logic data_mark_missing;
		logic step_pulse;
		logic pos_done;
	} fdcrs_event_t;

	// whole state of the flag block apart from the pin synchroniser
	typedef struct packed {
		fdcrs_state_t state;
		fdcrs_cmd_t   cmd;
		logic [6:0]   step_cnt;
		logic [1:0]   index_cnt;
		logic         index_prev;
		logic [1:0]   term_class;
		logic         pos_done;
		logic         eq_fault;
		logic         not_avail;
		logic         head_side;
		logic [1:0]   unit_pick;
		logic         cyl_end;
		logic         crc_mismatch;
		logic         host_late;
		logic         sector_missing;
		logic         media_protected;
		logic         id_sync_absent;
		logic         data_sync_absent;
	} fdcrs_regs_t;

endpackage : fdcrs_pkg

// *** fdcrs_sync.sv ***
// fdcrs_sync: two flip-flop synchroniser for the drive pin group
// assumes pins are slow levels; a pulse shorter than one clock may be missed
`timescale 1ns/1ps
module fdcrs_sync
(
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire fdcrs_pkg::fdcrs_drive_t pin_in,
	output fdcrs_pkg::fdcrs_drive_t   pin_sync
);

	fdcrs_pkg::fdcrs_drive_t meta_reg;
	fdcrs_pkg::fdcrs_drive_t sync_reg;

	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	assign pin_sync = sync_reg;

endmodule : fdcrs_sync

// *** fdcrs_flags.sv ***
// fdcrs_flags: result phase status flags of the floppy controller
// assumes the command sequencer runs on mclk and gives one-cycle events;
// drive pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module fdcrs_flags
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire fdcrs_pkg::fdcrs_drive_t drive_pins,
	input  wire logic                    cmd_start,
	input  wire fdcrs_pkg::fdcrs_cmd_t   cmd_class,
	input  wire logic                    cmd_head,
	input  wire logic                    cmd_done,
	input  wire fdcrs_pkg::fdcrs_event_t exec_event,
	input  wire logic                    int_raise,
	input  wire logic [1:0]              int_unit,
	input  wire logic                    int_head,
	input  wire logic [1:0]              int_term_class,
	output logic [7:0]                   command_outcome_status,
	output logic [7:0]                   transfer_fault_status,
	output logic                         data_sync_absent_flag,
	output logic                         exec_busy
);

	fdcrs_pkg::fdcrs_drive_t pins_s;
	fdcrs_pkg::fdcrs_regs_t  st_reg;
	fdcrs_pkg::fdcrs_regs_t  st_next;

	// pins pass two flip-flops before any use
	fdcrs_sync u_sync
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.pin_in   (drive_pins),
		.pin_sync (pins_s)
	);

	function automatic logic is_rw(input fdcrs_pkg::fdcrs_cmd_t c);
		case (c)
			fdcrs_pkg::FDCRS_CMD_READ,
			fdcrs_pkg::FDCRS_CMD_READ_DEL,
			fdcrs_pkg::FDCRS_CMD_WRITE,
			fdcrs_pkg::FDCRS_CMD_WRITE_DEL,
			fdcrs_pkg::FDCRS_CMD_FORMAT,
			fdcrs_pkg::FDCRS_CMD_READ_ID,
			fdcrs_pkg::FDCRS_CMD_READ_TRACK,
			fdcrs_pkg::FDCRS_CMD_SCAN:
			begin
				is_rw = 1'b1;
			end
			default:
			begin
				is_rw = 1'b0;
			end
		endcase
	endfunction : is_rw

	function automatic logic is_write(input fdcrs_pkg::fdcrs_cmd_t c);
		case (c)
			fdcrs_pkg::FDCRS_CMD_WRITE,
			fdcrs_pkg::FDCRS_CMD_WRITE_DEL,
			fdcrs_pkg::FDCRS_CMD_FORMAT:
			begin
				is_write = 1'b1;
			end
			default:
			begin
				is_write = 1'b0;
			end
		endcase
	endfunction : is_write

	function automatic logic is_sector_seek(input fdcrs_pkg::fdcrs_cmd_t c);
		case (c)
			fdcrs_pkg::FDCRS_CMD_READ,
			fdcrs_pkg::FDCRS_CMD_READ_DEL,
			fdcrs_pkg::FDCRS_CMD_WRITE_DEL,
			fdcrs_pkg::FDCRS_CMD_SCAN:
			begin
				is_sector_seek = 1'b1;
			end
			default:
			begin
				is_sector_seek = 1'b0;
			end
		endcase
	endfunction : is_sector_seek

	function automatic logic is_positioning(input fdcrs_pkg::fdcrs_cmd_t c);
		case (c)
			fdcrs_pkg::FDCRS_CMD_SEEK,
			fdcrs_pkg::FDCRS_CMD_RECAL:
			begin
				is_positioning = 1'b1;
			end
			default:
			begin
				is_positioning = 1'b0;
			end
		endcase
	endfunction : is_positioning

	logic                  exec_now;
	fdcrs_pkg::fdcrs_cmd_t cur_cmd;
	logic                  index_rise;
	// a count left over from the last command must not fire in the next start cycle
	logic                  step_limit_hit;
	logic                  index_limit_hit;

	// edge and limit detection feed the flag updates below
	always_comb
	begin
		index_rise      = pins_s.index && !st_reg.index_prev;
		step_limit_hit  = !cmd_start && (st_reg.step_cnt == fdcrs_pkg::RECAL_STEP_LIMIT);
		index_limit_hit = !cmd_start && (st_reg.index_cnt == fdcrs_pkg::INDEX_LIMIT);
	end

	always_comb
	begin
		st_next = st_reg;
		exec_now = 1'b0;
		cur_cmd = st_reg.cmd;
		st_next.index_prev = pins_s.index;

		// clear first, so every set below in the same cycle wins
		if (cmd_start)
		begin
			st_next.cmd             = cmd_class;
			cur_cmd                 = cmd_class;
			st_next.step_cnt        = '0;
			st_next.index_cnt       = '0;
			st_next.term_class      = '0;
			st_next.pos_done        = 1'b0;
			st_next.eq_fault        = 1'b0;
			st_next.not_avail       = 1'b0;
			st_next.head_side       = 1'b0;
			st_next.unit_pick       = '0;
			st_next.cyl_end         = 1'b0;
			st_next.crc_mismatch    = 1'b0;
			st_next.host_late       = 1'b0;
			st_next.sector_missing  = 1'b0;
			st_next.media_protected = 1'b0;
			st_next.id_sync_absent  = 1'b0;
			st_next.data_sync_absent = 1'b0;
		end

		case (st_reg.state)
			fdcrs_pkg::FDCRS_ST_IDLE:
			begin
				if (cmd_start)
				begin
					st_next.state = fdcrs_pkg::FDCRS_ST_EXEC;
				end
			end
			fdcrs_pkg::FDCRS_ST_EXEC:
			begin
				exec_now = 1'b1;
				if (cmd_done && !cmd_start)
				begin
					st_next.state = fdcrs_pkg::FDCRS_ST_IDLE;
				end
			end
			default:
			begin
				st_next.state = fdcrs_pkg::FDCRS_ST_IDLE;
			end
		endcase
		if (cmd_start)
		begin
			exec_now = 1'b1;
		end

		// drive readiness is judged as the command is taken
		if (cmd_start && is_rw(cmd_class))
		begin
			if (!pins_s.ready)
			begin
				st_next.not_avail = 1'b1;
			end
			if (cmd_head && !pins_s.two_side)
			begin
				st_next.not_avail = 1'b1;
			end
		end

		if (exec_now && is_positioning(cur_cmd) && exec_event.pos_done)
		begin
			st_next.pos_done = 1'b1;
		end

		// fault is watched at all times, not only in execution
		if (pins_s.fault)
		begin
			st_next.eq_fault = 1'b1;
		end

		// recalibrate step counter saturates at the limit
		if (exec_now && cur_cmd == fdcrs_pkg::FDCRS_CMD_RECAL)
		begin
			if (exec_event.step_pulse && st_next.step_cnt != fdcrs_pkg::RECAL_STEP_LIMIT)
			begin
				st_next.step_cnt = st_next.step_cnt + 7'h01;
			end
			if (step_limit_hit && !pins_s.track_zero)
			begin
				st_next.eq_fault = 1'b1;
				st_next.pos_done = 1'b1;
			end
		end

		if (exec_now && exec_event.beyond_last_sector)
		begin
			st_next.cyl_end = 1'b1;
		end

		if (exec_now && (exec_event.id_crc_err || exec_event.data_crc_err))
		begin
			st_next.crc_mismatch = 1'b1;
		end

		if (exec_now && exec_event.host_late)
		begin
			st_next.host_late = 1'b1;
		end

		if (exec_now && is_sector_seek(cur_cmd) && exec_event.sector_not_found)
		begin
			st_next.sector_missing = 1'b1;
		end

		if (exec_now && cur_cmd == fdcrs_pkg::FDCRS_CMD_READ_ID && exec_event.id_read_fail)
		begin
			st_next.sector_missing = 1'b1;
		end

		if (exec_now && cur_cmd == fdcrs_pkg::FDCRS_CMD_READ_TRACK
			&& exec_event.start_sector_lost)
		begin
			st_next.sector_missing = 1'b1;
		end

		if (exec_now && is_write(cur_cmd) && pins_s.write_protect)
		begin
			st_next.media_protected = 1'b1;
		end

		// index pulses counted since the last id mark, which clears the count
		if (exec_now && is_rw(cur_cmd))
		begin
			if (exec_event.id_mark_seen)
			begin
				st_next.index_cnt = '0;
			end
			else if (index_rise && st_next.index_cnt != fdcrs_pkg::INDEX_LIMIT)
			begin
				st_next.index_cnt = st_next.index_cnt + 2'h1;
			end
			if (index_limit_hit)
			begin
				st_next.id_sync_absent = 1'b1;
			end
		end

		if (exec_now && exec_event.data_mark_missing)
		begin
			st_next.id_sync_absent   = 1'b1;
			st_next.data_sync_absent = 1'b1;
		end

		// head, unit and class frozen at the interrupt
		if (int_raise)
		begin
			st_next.head_side  = int_head;
			st_next.unit_pick  = int_unit;
			st_next.term_class = int_term_class;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '{
				state: fdcrs_pkg::FDCRS_ST_IDLE,
				cmd: fdcrs_pkg::FDCRS_CMD_OTHER,
				default: '0
			};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// byte assembly is wiring only; every bit is a flip-flop except unused bits 3 and 6 of the transfer fault byte, tied to zero
	always_comb
	begin
		command_outcome_status = fdcrs_pkg::COS_RESET;
		command_outcome_status[fdcrs_pkg::COS_TERM_HI_BIT]   = st_reg.term_class[1];
		command_outcome_status[fdcrs_pkg::COS_TERM_LO_BIT]   = st_reg.term_class[0];
		command_outcome_status[fdcrs_pkg::COS_POS_DONE_BIT]  = st_reg.pos_done;
		command_outcome_status[fdcrs_pkg::COS_EQ_FAULT_BIT]  = st_reg.eq_fault;
		command_outcome_status[fdcrs_pkg::COS_NOT_AVAIL_BIT] = st_reg.not_avail;
		command_outcome_status[fdcrs_pkg::COS_HEAD_BIT]      = st_reg.head_side;
		command_outcome_status[fdcrs_pkg::COS_UNIT_HI_BIT]   = st_reg.unit_pick[1];
		command_outcome_status[fdcrs_pkg::COS_UNIT_LO_BIT]   = st_reg.unit_pick[0];
	end

	always_comb
	begin
		transfer_fault_status = fdcrs_pkg::TFS_RESET;
		transfer_fault_status[fdcrs_pkg::TFS_CYL_END_BIT] = st_reg.cyl_end;
		transfer_fault_status[fdcrs_pkg::TFS_UNUSED6_BIT] = 1'b0;
		transfer_fault_status[fdcrs_pkg::TFS_CRC_BIT]     = st_reg.crc_mismatch;
		transfer_fault_status[fdcrs_pkg::TFS_LATE_BIT]    = st_reg.host_late;
		transfer_fault_status[fdcrs_pkg::TFS_UNUSED3_BIT] = 1'b0;
		transfer_fault_status[fdcrs_pkg::TFS_MISSING_BIT] = st_reg.sector_missing;
		transfer_fault_status[fdcrs_pkg::TFS_PROTECT_BIT] = st_reg.media_protected;
		transfer_fault_status[fdcrs_pkg::TFS_ID_SYNC_BIT] = st_reg.id_sync_absent;
	end

	assign data_sync_absent_flag = st_reg.data_sync_absent;
	assign exec_busy             = (st_reg.state == fdcrs_pkg::FDCRS_ST_EXEC);

endmodule : fdcrs_flags

// *** fdcrs_flags_properties.sv ***
// fdcrs_flags_properties: port-level assertions for the result flag block
// assumes it is bound to every fdcrs_flags instance on the one mclk domain
`timescale 1ns/1ps
module fdcrs_flags_properties
(
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire fdcrs_pkg::fdcrs_drive_t drive_pins,
	input wire logic                    cmd_start,
	input wire fdcrs_pkg::fdcrs_cmd_t   cmd_class,
	input wire logic                    cmd_head,
	input wire logic                    cmd_done,
	input wire fdcrs_pkg::fdcrs_event_t exec_event,
	input wire logic                    int_raise,
	input wire logic [1:0]              int_unit,
	input wire logic                    int_head,
	input wire logic [1:0]              int_term_class,
	input wire logic [7:0]              command_outcome_status,
	input wire logic [7:0]              transfer_fault_status,
	input wire logic                    data_sync_absent_flag,
	input wire logic                    exec_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_live;
		exec_busy || cmd_start;
	endsequence
	// pin passes two sync stages, so three held samples are needed
	sequence s_fault_held;
		drive_pins.fault [*3];
	endsequence
	property p_fault;
		s_fault_held |=> command_outcome_status[4];
	endproperty
	property p_unused;
		transfer_fault_status[6] == 1'b0 && transfer_fault_status[3] == 1'b0;
	endproperty
	property p_crc;
		s_live ##0 (exec_event.id_crc_err || exec_event.data_crc_err) |=> transfer_fault_status[5];
	endproperty
	property p_late;
		s_live ##0 exec_event.host_late |=> transfer_fault_status[4];
	endproperty
	property p_cyl;
		s_live ##0 exec_event.beyond_last_sector |=> transfer_fault_status[7];
	endproperty
	property p_sync;
		s_live ##0 exec_event.data_mark_missing |=> transfer_fault_status[0] && data_sync_absent_flag;
	endproperty
	property p_int;
		int_raise && !cmd_start |=> {command_outcome_status[7:6], command_outcome_status[2:0]}
			== {$past(int_term_class), $past(int_head), $past(int_unit)};
	endproperty
	property p_clear;
		cmd_start && cmd_class == fdcrs_pkg::FDCRS_CMD_SEEK && exec_event == '0
			|=> transfer_fault_status == 8'h00 && exec_busy;
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault flag not set");
	a_unused: assert property (p_unused)
		else $error("unused bit set");
	a_crc: assert property (p_crc)
		else $error("crc flag not set");
	a_late: assert property (p_late)
		else $error("late flag not set");
	a_cyl: assert property (p_cyl)
		else $error("cylinder end flag not set");
	a_sync: assert property (p_sync)
		else $error("sync flags not set");
	a_int: assert property (p_int)
		else $error("interrupt fields wrong");
	a_clear: assert property (p_clear)
		else $error("flags not cleared");
endmodule : fdcrs_flags_properties
bind fdcrs_flags fdcrs_flags_properties u_props (.mclk, .rst_n, .drive_pins, .cmd_start,
	.cmd_class, .cmd_head, .cmd_done, .exec_event, .int_raise, .int_unit, .int_head,
	.int_term_class, .command_outcome_status, .transfer_fault_status, .data_sync_absent_flag,
	.exec_busy);

// *** fdcrs_drive_model.sv ***
// fdcrs_drive_model: behavioural floppy drive feeding the flag block pins
// assumes levels come from the bench; the disk spins always, so index runs free
`timescale 1ns/1ps
module fdcrs_drive_model
#(
	parameter int TZ_STEPS    = 100,
	parameter int INDEX_EVERY = 60
)
(
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               step_pulse,
	input  wire logic               fault,
	input  wire logic               ready,
	input  wire logic               two_side,
	input  wire logic               write_protect,
	output fdcrs_pkg::fdcrs_drive_t pins
);
	int steps;
	int rot;
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			steps <= 0;
			rot   <= 0;
		end
		else
		begin
			rot <= (rot == INDEX_EVERY - 1) ? 0 : rot + 1;
			if (step_pulse)
				steps <= steps + 1;
		end
	end
	// head starts far out; index held four clocks so the synchroniser sees it
	assign pins = {fault, ready, two_side, steps >= TZ_STEPS, write_protect, rot < 4};
endmodule : fdcrs_drive_model

// *** fdcrs_flags_tb_top.sv ***
// fdcrs_flags_tb_top: self-checking bench for the result flag block
// assumes the drive model and the bound checker are compiled alongside
`timescale 1ns/1ps
module fdcrs_flags_tb_top;
	logic                    mclk = 1'b0;
	logic                    rst_n = 1'b0;
	fdcrs_pkg::fdcrs_drive_t pins;
	logic                    cmd_start = 1'b0;
	fdcrs_pkg::fdcrs_cmd_t   cmd_class = fdcrs_pkg::FDCRS_CMD_OTHER;
	logic                    cmd_head = 1'b0;
	logic                    cmd_done = 1'b0;
	fdcrs_pkg::fdcrs_event_t ev_r = '0;
	logic                    int_raise = 1'b0;
	logic [1:0]              int_unit = 2'h0;
	logic                    int_head = 1'b0;
	logic [1:0]              int_term = 2'h0;
	logic                    fault = 1'b0;
	logic                    ready = 1'b0;
	logic                    two_side = 1'b1;
	logic                    wprot = 1'b0;
	logic [7:0]              cos;
	logic [7:0]              tfs;
	logic                    dsa;
	int                      bad_count = 0;
	int                      total_checks = 0;
	int                      cycles = 0;
	logic [3:0]  t_cls [10] = '{4'h2, 4'h2, 4'h2, 4'h5, 4'h9, 4'h7, 4'h8, 4'h2, 4'h2, 4'h2};
	logic [10:0] t_ev [10] = '{11'h100, 11'h010, 11'h080, 11'h080, 11'h080, 11'h040, 11'h020,
		11'h040, 11'h400, 11'h004};
	logic [7:0]  t_tfs [10] = '{8'h10, 8'h80, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h20,
		8'h01};
	logic [3:0]  w_cls [4] = '{4'h4, 4'h5, 4'h6, 4'h2};
	fdcrs_drive_model u_drive (.mclk, .rst_n, .step_pulse(ev_r.step_pulse), .fault, .ready,
		.two_side, .write_protect(wprot), .pins);
	fdcrs_flags dut (.mclk, .rst_n, .drive_pins(pins), .cmd_start, .cmd_class, .cmd_head,
		.cmd_done, .exec_event(ev_r), .int_raise, .int_unit, .int_head,
		.int_term_class(int_term), .command_outcome_status(cos), .transfer_fault_status(tfs),
		.data_sync_absent_flag(dsa), .exec_busy());
	always #5 mclk = ~mclk;
	task automatic final_report();
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	task automatic start(input logic [3:0] c, input logic h);
		@(negedge mclk);
		cmd_start = 1'b1;
		cmd_class = fdcrs_pkg::fdcrs_cmd_t'(c);
		cmd_head = h;
		@(negedge mclk);
		cmd_start = 1'b0;
	endtask : start
	task automatic ev(input logic [10:0] e);
		@(negedge mclk);
		ev_r = e;
		@(negedge mclk);
		ev_r = '0;
	endtask : ev
	task automatic finish_cmd();
		@(negedge mclk);
		cmd_done = 1'b1;
		@(negedge mclk);
		cmd_done = 1'b0;
	endtask : finish_cmd
	// hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			bad_count++;
			final_report();
		end
	end
	initial
	begin
		tick(20);
		rst_n = 1'b1;
		tick(5);
		chk(cos, 8'h00);
		chk(tfs, 8'h00);
		start(4'h2, 1'b0);
		chk(cos, 8'h08);
		ev(11'h200);
		chk(tfs, 8'h20);
		@(negedge mclk);
		int_raise = 1'b1;
		int_unit = 2'h1;
		int_head = 1'b1;
		int_term = 2'h1;
		@(negedge mclk);
		int_raise = 1'b0;
		chk(cos, 8'h4D);
		finish_cmd();
		ready = 1'b1;
		two_side = 1'b0;
		tick(5);
		start(4'h2, 1'b1);
		chk(cos, 8'h08);
		finish_cmd();
		two_side = 1'b1;
		tick(5);
		start(4'h0, 1'b0);
		chk(cos, 8'h00);
		chk(tfs, 8'h00);
		ev(11'h001);
		chk(cos, 8'h20);
		finish_cmd();
		for (int i = 0; i < 10; i++)
		begin
			start(t_cls[i], 1'b0);
			ev(t_ev[i]);
			chk(tfs, t_tfs[i]);
			chk({7'h00, dsa}, {7'h00, t_ev[i] == 11'h004});
			finish_cmd();
		end
		wprot = 1'b1;
		tick(5);
		for (int i = 0; i < 4; i++)
		begin
			start(w_cls[i], 1'b0);
			tick(4);
			chk(tfs, (i < 3) ? 8'h02 : 8'h00);
			finish_cmd();
		end
		wprot = 1'b0;
		fault = 1'b1;
		tick(5);
		chk(cos & 8'h10, 8'h10);
		fault = 1'b0;
		tick(5);
		start(4'h1, 1'b0);
		repeat (76) ev(11'h002);
		tick(2);
		chk(cos & 8'h30, 8'h00);
		ev(11'h002);
		tick(2);
		chk(cos & 8'h30, 8'h30);
		finish_cmd();
		start(4'h1, 1'b0);
		chk(cos & 8'h30, 8'h00);
		finish_cmd();
		start(4'h2, 1'b0);
		tick(150);
		chk(tfs, 8'h01);
		finish_cmd();
		start(4'h2, 1'b0);
		chk(tfs, 8'h00);
		finish_cmd();
		final_report();
	end
endmodule : fdcrs_flags_tb_top
